// File: dv/fcp_disk_model.sv
`timescale 1ns/1ns
module fcp_disk_model (
	input  wire logic        clk,
	input  wire logic        sector_req,
	input  wire logic [7:0]  sector_num,
	input  wire logic        head_sel,
	input  wire logic [7:0]  del_mask,
	input  wire logic [15:0] n_bytes,
	input  wire logic [7:0]  gap,
	output logic             sector_ack,
	output logic             sector_deleted,
	output logic             disk_rd_valid,
	output logic [7:0]       disk_rd_data
);
	logic [8:0] req_q[$];
	logic [8:0] cur;

	// Requests queue up while an earlier sector still streams past the head
	always @(posedge clk) begin
		if (sector_req === 1'b1)
			req_q.push_back({head_sel, sector_num});
	end

	// One sector at a time; odd sectors answer one cycle slower
	initial begin
		sector_ack = 1'b0;
		sector_deleted = 1'b0;
		disk_rd_valid = 1'b0;
		disk_rd_data = 8'h00;
		forever begin
			@(posedge clk);
			if (req_q.size() != 0) begin
				cur = req_q.pop_front();
				repeat (3 + cur[0]) @(posedge clk);
				sector_ack <= 1'b1;
				sector_deleted <= del_mask[cur[2:0]];
				@(posedge clk);
				sector_ack <= 1'b0;
				sector_deleted <= ~del_mask[cur[2:0]];
				// Data field streams whole; the line flips between bytes
				for (int i = 0; i < n_bytes; i++) begin
					disk_rd_valid <= 1'b1;
					disk_rd_data <= {cur[8], cur[2:0], i[3:0]};
					@(posedge clk);
					disk_rd_valid <= 1'b0;
					disk_rd_data <= ~{cur[8], cur[2:0], i[3:0]};
					repeat (gap - 1) @(posedge clk);
				end
			end
		end
	end
endmodule

// File: dv/fcp_engine_properties.sv
`timescale 1ns/1ns
`include "fcp_params.svh"
module fcp_engine_properties #(
	parameter int STEP_UNIT_CYC = 4,
	parameter int POLL_CYC      = 8
) (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire fcp_pkg::fcp_bus_s bus,
	input wire logic [7:0]        rdata,
	input wire logic              host_irq,
	input wire logic              dma_request,
	input wire logic              dma_acknowledge,
	input wire logic              sector_req,
	input wire logic [7:0]        sector_num,
	input wire logic              head_sel,
	input wire logic              sector_ack,
	input wire logic              sector_deleted,
	input wire logic              disk_rd_valid,
	input wire logic [7:0]        disk_rd_data,
	input wire logic              disk_wr_valid,
	input wire logic [7:0]        disk_wr_data,
	input wire logic              write_enable,
	input wire logic              step_pulse,
	input wire logic              step_dir_in,
	input wire logic              poll_tick,
	input wire logic              precomp_on,
	input wire logic [3:0]        perp_bits
);
	import fcp_pkg::*;
	logic [7:0] pcn_reg, pcn_next, trk_reg, trk_next, wd_reg;
	logic [3:0] srt_reg, srt_next;
	logic       npol_reg, npol_next, npol_old_reg, seen_reg, seen_next;
	int         gap_reg, gap_next;

	// Shadows of software writes and head position; gap restarts at each step pulse
	always_comb begin
		pcn_next = pcn_reg;
		trk_next = trk_reg;
		srt_next = srt_reg;
		npol_next = npol_reg;
		seen_next = (seen_reg || step_pulse) && !(bus.wr && bus.addr == `FCP_A_CMD);
		gap_next = step_pulse ? 0 : gap_reg + 1;
		if (step_pulse)
			pcn_next = step_dir_in ? pcn_reg - 8'h01 : pcn_reg + 8'h01;
		if (bus.wr && bus.addr == `FCP_A_PRECOMP_BEGIN_TRACK)
			trk_next = bus.wdata;
		if (bus.wr && bus.addr == `FCP_A_MODE) begin
			srt_next = bus.wdata[`FCP_MODE_SRT];
			npol_next = bus.wdata[`FCP_MODE_NPOL];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pcn_reg <= 8'h00;
			trk_reg <= 8'h00;
			srt_reg <= 4'h0;
			npol_reg <= 1'b0;
			npol_old_reg <= 1'b0;
			seen_reg <= 1'b0;
			gap_reg <= 0;
			wd_reg <= 8'h00;
		end else begin
			pcn_reg <= pcn_next;
			trk_reg <= trk_next;
			srt_reg <= srt_next;
			npol_reg <= npol_next;
			npol_old_reg <= npol_reg;
			seen_reg <= seen_next;
			gap_reg <= gap_next;
			wd_reg <= bus.wdata;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_reg_read(logic [3:0] a);
		bus.rd && bus.addr == a && !step_pulse;
	endsequence
	sequence s_perp_write(logic g);
		bus.wr && bus.addr == `FCP_A_PERP && bus.wdata[`FCP_PERP_GATE] == g;
	endsequence

	a_rdata_quiet: assert property (!bus.rd |=> rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_pcn_report: assert property (s_reg_read(`FCP_A_PCYL) |=> rdata == pcn_reg)
		else $error("present cylinder read wrong");
	a_precomp_track: assert property ((bus.wr && bus.addr == `FCP_A_PRECOMP_BEGIN_TRACK)
		|-> ##2 precomp_on == (pcn_reg >= trk_reg))
		else $error("precompensation level wrong");
	a_perp_open: assert property (s_perp_write(1'b1) |=> perp_bits == wd_reg[3:0])
		else $error("drive bits not loaded");
	a_perp_shut: assert property (s_perp_write(1'b0) |=> $stable(perp_bits))
		else $error("drive bits changed with gate clear");
	a_poll_gate: assert property (poll_tick |-> !(npol_reg && npol_old_reg))
		else $error("poll tick while polling off");
	a_step_interval: assert property (step_pulse && seen_reg
		|-> gap_reg == (srt_reg + 1) * STEP_UNIT_CYC - 1)
		else $error("step spacing wrong");
	a_dir_steady: assert property (step_pulse |-> $stable(step_dir_in))
		else $error("step direction moved at pulse");
	a_dma_release: assert property ($fell(dma_request) |-> $past(bus.rd) || $past(bus.wr))
		else $error("request dropped without access");
	a_dma_no_irq: assert property (dma_request |-> !host_irq)
		else $error("interrupt during transfer request");
	a_sreq_single: assert property (sector_req |=> !sector_req)
		else $error("sector request longer than one cycle");
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ns
`include "fcp_params.svh"
module testbench;
	import fcp_pkg::*;
	typedef struct packed {
		logic [3:0] a;
		logic [7:0] w;
	} fcp_row_s;
	localparam int STEP_UNIT = 4;
	localparam int POLL      = 8;
	logic              clk, rst_n, host_irq, dma_request, dma_acknowledge, sector_req;
	logic              head_sel, sector_ack, sector_deleted, disk_rd_valid, step_pulse;
	logic              step_dir_in, poll_tick, precomp_on;
	logic [7:0]        rdata, sector_num, disk_rd_data, del_mask, gap, d;
	logic [3:0]        perp_bits;
	logic [15:0]       n_bytes;
	fcp_pkg::fcp_bus_s bus;
	logic [8:0]        sect_q[$];
	int                err_total, n_tests, cyc, k;
	fcp_row_s          rows[8] = '{'{4'h1, 8'h05}, '{4'h2, 8'h09}, '{4'h3, 8'h07},
		'{4'h4, 8'h80}, '{4'h5, 8'h0c}, '{4'h6, 8'ha5}, '{4'h7, 8'h33}, '{4'h8, 8'hfd}};
	logic [8:0]        exp_sec[5] = '{9'h002, 9'h003, 9'h101, 9'h102, 9'h103};
	logic [15:0]       cnt_cmd[2] = '{16'h0302, 16'h0403};

	fcp_engine #(.STEP_UNIT_CYC(STEP_UNIT), .POLL_CYC(POLL)) uut (
		.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .host_irq(host_irq),
		.dma_request(dma_request), .dma_acknowledge(dma_acknowledge),
		.sector_req(sector_req), .sector_num(sector_num), .head_sel(head_sel),
		.sector_ack(sector_ack), .sector_deleted(sector_deleted),
		.disk_rd_valid(disk_rd_valid), .disk_rd_data(disk_rd_data), .disk_wr_valid(),
		.disk_wr_data(), .write_enable(), .step_pulse(step_pulse),
		.step_dir_in(step_dir_in), .poll_tick(poll_tick), .precomp_on(precomp_on),
		.perp_bits(perp_bits));
	fcp_disk_model disk (
		.clk, .sector_req, .sector_num, .head_sel, .del_mask, .n_bytes, .gap, .sector_ack,
		.sector_deleted, .disk_rd_valid, .disk_rd_data);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Cycle count doubles as the hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			print_verdict();
		end
	end
	always @(posedge clk) begin
		if (sector_req === 1'b1)
			sect_q.push_back({head_sel, sector_num});
	end

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			$display("unexpected %s: expected %h, seen %h", what, e, g);
			err_total++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] w);
		@(posedge clk);
		bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] q);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		q = rdata;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] q;
		rd(a, q);
		chk($sformatf("register %h", a), e, q & m);
	endtask
	task automatic wait_irq(input int lim);
		for (int i = 0; i < lim; i++) begin
			@(negedge clk);
			if (host_irq === 1'b1)
				return;
		end
		chk("host_irq", 16'h1, 16'h0);
	endtask
	// Acknowledge stays high across the data access, as a system DMA does
	task automatic dma_byte(output logic [7:0] q);
		for (int i = 0; i < 6000 && dma_request !== 1'b1; i++)
			@(negedge clk);
		@(posedge clk);
		dma_acknowledge <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`FCP_A_DATA, q);
		chk("dma_request", 16'h0, dma_request);
		@(posedge clk);
		dma_acknowledge <= 1'b0;
	endtask
	task automatic seek(input logic [7:0] off, input int n, input logic dir);
		int cnt;
		int last;
		cnt = 0;
		last = 0;
		wr(`FCP_A_RSTEP, off);
		wr(`FCP_A_CMD, 8'h05);
		for (int i = 0; i < 300 && host_irq !== 1'b1; i++) begin
			@(negedge clk);
			if (step_pulse === 1'b1) begin
				if (cnt > 0)
					chk("step gap", 16'(2 * STEP_UNIT), 16'(cyc - last));
				chk("step dir", dir, step_dir_in);
				cnt++;
				last = cyc;
			end
		end
		chk("steps", 16'(n), 16'(cnt));
	endtask

	initial begin
		rst_n = 1'b0;
		bus = '0;
		dma_acknowledge = 1'b0;
		del_mask = 8'h00;
		gap = 8'd8;
		n_bytes = 16'd128;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		// Register table: write then read back
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rchk(rows[i].a, rows[i].w, 8'hff);
		end
		// Drive bits load only with the gate set
		wr(`FCP_A_PERP, 8'h8a);
		wr(`FCP_A_PERP, 8'h05);
		chk("perp_bits", 16'ha, perp_bits);
		// Polling runs, then stops
		for (int p = 0; p < 2; p++) begin
			wr(`FCP_A_MODE, p ? 8'h04 : 8'h00);
			// A tick launched under the old mode may still show here
			@(negedge clk);
			k = 0;
			repeat (4 * POLL) begin
				@(negedge clk);
				k += poll_tick;
			end
			chk("poll ticks", p ? 16'h0 : 16'h1, p ? k : (k >= 3));
		end
		// Relative seeks out and back, then sense
		wr(`FCP_A_MODE, 8'h14);
		seek(8'h03, 3, 1'b0);
		rchk(`FCP_A_PCYL, 8'h03, 8'hff);
		rchk(`FCP_A_RS0, 8'h20, 8'h20);
		rchk(`FCP_A_RS1, 8'h00, 8'hff);
		seek(8'hfe, 2, 1'b1);
		wr(`FCP_A_CMD, 8'h06);
		wait_irq(50);
		rchk(`FCP_A_PCYL, 8'h01, 8'hff);
		for (int t = 1; t < 3; t++) begin
			wr(`FCP_A_PRECOMP_BEGIN_TRACK, t[7:0]);
			repeat (2) @(negedge clk);
			chk("precomp_on", t == 1, precomp_on);
		end
		// Spanning read, programmed transfer, short data length
		sect_q = {};
		wr(`FCP_A_SECT, 8'h02);
		wr(`FCP_A_EOT, 8'h03);
		wr(`FCP_A_SIZE, 8'h00);
		wr(`FCP_A_DLEN, 8'h02);
		wr(`FCP_A_MODE, 8'h05);
		wr(`FCP_A_CMD, 8'h10);
		for (int s = 0; s < 10; s++) begin
			wait_irq(2000);
			rd(`FCP_A_DATA, d);
			chk("pio byte", {exp_sec[s/2][8], exp_sec[s/2][2:0], 3'h0, s[0]}, d);
		end
		wait_irq(3000);
		chk("sector total", 16'd5, sect_q.size());
		foreach (exp_sec[s])
			chk("sector id", exp_sec[s], sect_q[s]);
		// DMA read of 256-byte sectors, deleted sector skipped
		sect_q = {};
		del_mask = 8'h04;
		gap = 8'd16;
		n_bytes = 16'd256;
		wr(`FCP_A_SECT, 8'h01);
		wr(`FCP_A_SIZE, 8'h01);
		wr(`FCP_A_MODE, 8'h04);
		wr(`FCP_A_CMD, 8'h20);
		for (int b = 0; b < 512; b++) begin
			dma_byte(d);
			chk("dma byte", {1'b0, b[8] ? 3'h3 : 3'h1, b[3:0]}, d);
		end
		wait_irq(6000);
		chk("skip sectors", 16'd3, sect_q.size());
		rchk(`FCP_A_RS2, 8'h40, 8'h40);
		// Count-driven verify and format
		n_bytes = 16'd4;
		wr(`FCP_A_EOT, 8'h09);
		foreach (cnt_cmd[c]) begin
			sect_q = {};
			wr(`FCP_A_SCNT, cnt_cmd[c][7:0]);
			wr(`FCP_A_MODE, 8'h06);
			wr(`FCP_A_CMD, cnt_cmd[c][15:8]);
			wait_irq(3000);
			chk("count sectors", cnt_cmd[c][7:0], sect_q.size());
		end
		print_verdict();
	end
endmodule

bind fcp_engine fcp_engine_properties #(.STEP_UNIT_CYC(STEP_UNIT_CYC), .POLL_CYC(POLL_CYC)) u_props (
	.clk, .rst_n, .bus, .rdata, .host_irq, .dma_request, .dma_acknowledge, .sector_req,
	.sector_num, .head_sel, .sector_ack, .sector_deleted, .disk_rd_valid, .disk_rd_data,
	.disk_wr_valid, .disk_wr_data, .write_enable, .step_pulse, .step_dir_in, .poll_tick,
	.precomp_on, .perp_bits);

// File: hw/fcp_engine.sv
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "fcp_params.svh"
// Notes on behaviour
// - Span flag makes both heads of a cylinder one long track.
// - After last sector of head 0, continue at sector 1 of head 1.
// - Sector bytes are 128 shifted left by size code, codes up to 7.
// - Size code 0 transfers data length bytes of the 128-byte sector.
// - Programmed mode: no DMA, host interrupt pulse for every byte.
// - DMA mode: request raised, byte moves on acknowledge.
// - Perpendicular drive bits change only with the gate bit set.
// - Polling ticks run only while polling disable is clear.
// - Precompensation start track programmable 00 to ff.
// - First sector of a transfer is the sector address, then onward.
// - Relative seek offset steps the present cylinder by that amount.
// - Sector count sizes format, and verify when count enable set.
// - Read with bypass set skips sectors with deleted mark.
// - Deleted read with bypass touches only deleted sectors.
// - Step interval 0.5 ms units, 0.5 to 8 ms.
// - Result status 0 and 2 held after a command for the host; status 3 is live.
// - Sense command reports present cylinder.
// - Write gate bit moves write enable earlier for pre-erase.
// - Count enable makes verify use sector count as its length.
module fcp_engine #(
	parameter int STEP_UNIT_CYC = `FCP_STEP_UNIT_US * `FCP_CLK_MHZ,
	parameter int POLL_CYC      = `FCP_POLL_US * `FCP_CLK_MHZ
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire fcp_pkg::fcp_bus_s bus,
	output logic [7:0]         rdata,
	output logic               host_irq,
	output logic               dma_request,
	input  wire logic          dma_acknowledge,
	output logic               sector_req,
	output logic [7:0]         sector_num,
	output logic               head_sel,
	input  wire logic          sector_ack,
	input  wire logic          sector_deleted,
	input  wire logic          disk_rd_valid,
	input  wire logic [7:0]    disk_rd_data,
	output logic               disk_wr_valid,
	output logic [7:0]         disk_wr_data,
	output logic               write_enable,
	output logic               step_pulse,
	output logic               step_dir_in,
	output logic               poll_tick,
	output logic               precomp_on,
	output logic [3:0]         perp_bits
);
	import fcp_pkg::*;

	// Software-visible parameter registers
	logic [7:0] cmd_reg, cmd_next, sect_p_reg, sect_p_next, eot_reg, eot_next;
	logic [7:0] size_reg, size_next, dlen_reg, dlen_next, scnt_reg, scnt_next;
	logic [7:0] mode_reg, mode_next, precomp_begin_track_reg, precomp_begin_track_next;
	logic [7:0] rstep_reg, rstep_next;
	logic [3:0] perp_reg, perp_next;

	// Engine state
	fcp_state_e st_reg, st_next;
	fcp_cmd_s   cur_reg, cur_next;
	logic [7:0] sect_reg, sect_next, left_reg, left_next, data_reg, data_next;
	logic [7:0] pcn_reg, pcn_next, stepl_reg, stepl_next;
	logic [7:0] rs0_reg, rs0_next, rs2_reg, rs2_next;
	logic [14:0] idx_reg, idx_next;
	logic [31:0] tmr_reg, tmr_next, poll_reg, poll_next;
	logic       head_reg, head_next, req_reg, req_next, last_reg, last_next;
	logic       irq_reg, irq_next, sreq_reg, sreq_next, dwr_reg, dwr_next;
	logic       stp_reg, stp_next, dir_reg, dir_next, ptk_reg, ptk_next;
	logic [7:0] rd_reg, rd_next;
	logic       ack_s1, ack_s2;

	logic        wr_cmd, rd_dat, wr_dat, ack, span_end, sc_based, last_sect;
	logic        mismatch, is_wr;
	logic [14:0] sz_bytes, lim_bytes;
	logic [31:0] step_cyc;

	// Acknowledge pin crosses in through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			ack_s1 <= dma_acknowledge;
			ack_s2 <= ack_s1;
		end
	end

	assign wr_cmd = bus.wr && bus.addr == `FCP_A_CMD && st_reg == FCP_IDLE;
	assign rd_dat = bus.rd && bus.addr == `FCP_A_DATA;
	assign wr_dat = bus.wr && bus.addr == `FCP_A_DATA;
	assign is_wr  = cur_reg.op == FCP_OP_WRITE;
	// byte taken by host access alone; DMA needs acknowledge too
	assign ack = req_reg && (is_wr ? wr_dat : rd_dat)
		&& (cur_reg.programmed_io_select || ack_s2);

	assign sz_bytes = `FCP_BASE_BYTES << cur_reg.size_code;
	// code 0 limits bytes moved to the data length
	assign lim_bytes = (cur_reg.size_code == 3'h0) ?
		{7'h00, cur_reg.data_length_param} : sz_bytes;
	// half-millisecond units, code 0 gives 0.5 ms, 15 gives 8 ms
	assign step_cyc = (32'(mode_reg[`FCP_MODE_SRT]) + 32'h1) * 32'(STEP_UNIT_CYC);
	// count-driven length for format, and verify under count enable
	assign sc_based = cur_reg.op == FCP_OP_FORMAT ||
		(cur_reg.op == FCP_OP_VERIFY && cur_reg.verify_count_enable);
	// end of track only at head 1 when spanning
	assign span_end = sect_reg == cur_reg.eot &&
		!(cur_reg.cylinder_span_flag && !head_reg);
	assign last_sect = last_reg || (sc_based ? left_reg == 8'h01 : span_end);
	// sector whose mark disagrees with the read kind
	assign mismatch = sector_deleted ^ (cur_reg.op == FCP_OP_READDEL);

	// Parameter register writes; values may change freely while busy
	always_comb begin
		cmd_next    = cmd_reg;
		sect_p_next = sect_p_reg;
		eot_next    = eot_reg;
		size_next   = size_reg;
		dlen_next   = dlen_reg;
		scnt_next   = scnt_reg;
		mode_next   = mode_reg;
		precomp_begin_track_next = precomp_begin_track_reg;
		rstep_next  = rstep_reg;
		perp_next   = perp_reg;
		if (bus.wr) begin
			unique case (bus.addr)
				`FCP_A_CMD:    cmd_next = bus.wdata;
				`FCP_A_SECT:   sect_p_next = bus.wdata;
				`FCP_A_EOT:    eot_next = bus.wdata;
				`FCP_A_SIZE:   size_next = {5'h00, bus.wdata[2:0]};
				`FCP_A_DLEN:   dlen_next = bus.wdata;
				`FCP_A_SCNT:   scnt_next = bus.wdata;
				`FCP_A_MODE:   mode_next = bus.wdata;
				`FCP_A_PRECOMP_BEGIN_TRACK: precomp_begin_track_next = bus.wdata;
				`FCP_A_RSTEP:  rstep_next = bus.wdata;
				// drive bits held unless gate bit set
				`FCP_A_PERP: begin
					if (bus.wdata[`FCP_PERP_GATE])
						perp_next = bus.wdata[`FCP_PERP_BITS];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{cmd_reg, sect_p_reg, eot_reg, size_reg, dlen_reg} <=
				{`FCP_RST_BYTE, `FCP_RST_SECT, `FCP_RST_BYTE, `FCP_RST_BYTE, `FCP_RST_DLEN};
			{scnt_reg, mode_reg, precomp_begin_track_reg, rstep_reg, perp_reg} <=
				{`FCP_RST_BYTE, `FCP_RST_BYTE, `FCP_RST_BYTE, `FCP_RST_BYTE, 4'h0};
		end else begin
			{cmd_reg, sect_p_reg, eot_reg, size_reg, dlen_reg} <=
				{cmd_next, sect_p_next, eot_next, size_next, dlen_next};
			{scnt_reg, mode_reg, precomp_begin_track_reg, rstep_reg, perp_reg} <=
				{scnt_next, mode_next, precomp_begin_track_next, rstep_next, perp_next};
		end
	end

	// Command engine
	always_comb begin
		st_next    = st_reg;
		cur_next   = cur_reg;
		sect_next  = sect_reg;
		head_next  = head_reg;
		left_next  = left_reg;
		idx_next   = idx_reg;
		data_next  = data_reg;
		req_next   = req_reg;
		last_next  = last_reg;
		pcn_next   = pcn_reg;
		stepl_next = stepl_reg;
		dir_next   = dir_reg;
		tmr_next   = tmr_reg;
		rs0_next   = rs0_reg;
		rs2_next   = rs2_reg;
		irq_next   = 1'b0;
		sreq_next  = 1'b0;
		dwr_next   = 1'b0;
		stp_next   = 1'b0;
		// Host write lands in the data byte while a write waits for it
		if (ack && is_wr)
			data_next = bus.wdata;
		unique case (st_reg)
			FCP_IDLE: begin
				if (wr_cmd) begin
					// freeze parameters for the whole command
					cur_next.op = fcp_op_e'(bus.wdata[`FCP_CMD_OP]);
					cur_next.cylinder_span_flag = bus.wdata[`FCP_CMD_SPAN];
					cur_next.deleted_mark_bypass = bus.wdata[`FCP_CMD_SKIP];
					cur_next.programmed_io_select = mode_reg[`FCP_MODE_PIO];
					cur_next.verify_count_enable = mode_reg[`FCP_MODE_EC];
					cur_next.size_code = size_reg[2:0];
					cur_next.eot = eot_reg;
					// verify length taken from sector count when count enable set
					cur_next.data_length_param = (mode_reg[`FCP_MODE_EC] &&
						bus.wdata[`FCP_CMD_OP] == FCP_OP_VERIFY) ? scnt_reg : dlen_reg;
					cur_next.sector_count = scnt_reg;
					// first sector is the sector address
					sect_next = sect_p_reg;
					head_next = 1'b0;
					left_next = scnt_reg;
					last_next = 1'b0;
					rs0_next  = 8'h00;
					rs2_next  = 8'h00;
					unique case (bus.wdata[`FCP_CMD_OP])
						FCP_OP_RSEEK: begin
							dir_next   = rstep_reg[7];
							stepl_next = rstep_reg[7] ? 8'(-rstep_reg) : rstep_reg;
							tmr_next   = step_cyc;
							st_next    = FCP_STEP;
						end
						FCP_OP_SENSE, FCP_OP_NONE: st_next = FCP_DONE;
						default: begin
							sreq_next = 1'b1;
							st_next   = FCP_SECT;
						end
					endcase
				end
			end
			FCP_SECT: begin
				if (sector_ack) begin
					idx_next = 15'h0000;
					if (sc_based) begin
						st_next = FCP_NEXT;
					end else if (!is_wr && cur_reg.op != FCP_OP_VERIFY && mismatch) begin
						rs2_next[6] = 1'b1;
						// skip, or read it and stop after
						if (cur_reg.deleted_mark_bypass)
							st_next = FCP_NEXT;
						else begin
							last_next = 1'b1;
							st_next   = FCP_XFER;
						end
					end else begin
						st_next = FCP_XFER;
					end
				end
			end
			FCP_XFER: begin
				if (is_wr) begin
					if (idx_reg >= lim_bytes) begin
						// Fill beyond the moved length with zeros
						data_next = 8'h00;
						dwr_next  = 1'b1;
						idx_next  = idx_reg + 15'h0001;
					end else if (!req_reg) begin
						req_next = 1'b1;
						irq_next = cur_reg.programmed_io_select;
					end else if (ack) begin
						req_next = 1'b0;
						dwr_next = 1'b1;
						idx_next = idx_reg + 15'h0001;
					end
				end else if (req_reg) begin
					if (ack) begin
						req_next = 1'b0;
						idx_next = idx_reg + 15'h0001;
					end
				end else if (disk_rd_valid) begin
					data_next = disk_rd_data;
					// bytes past the length are checked, not moved
					if (idx_reg < lim_bytes && cur_reg.op != FCP_OP_VERIFY) begin
						req_next = 1'b1;
						irq_next = cur_reg.programmed_io_select;
					end else
						idx_next = idx_reg + 15'h0001;
				end
				if (idx_next == sz_bytes && !req_next)
					st_next = FCP_NEXT;
			end
			FCP_NEXT: begin
				if (last_sect) begin
					st_next = FCP_DONE;
				end else begin
					// roll onto head 1 sector 1
					if (sect_reg == cur_reg.eot) begin
						head_next = 1'b1;
						sect_next = 8'h01;
					end else
						sect_next = sect_reg + 8'h01;
					left_next = left_reg - 8'h01;
					sreq_next = 1'b1;
					st_next   = FCP_SECT;
				end
			end
			FCP_STEP: begin
				if (stepl_reg == 8'h00) begin
					rs0_next[5] = 1'b1;
					st_next     = FCP_DONE;
				end else if (tmr_reg <= 32'h1) begin
					stp_next   = 1'b1;
					stepl_next = stepl_reg - 8'h01;
					pcn_next   = dir_reg ? pcn_reg - 8'h01 : pcn_reg + 8'h01;
					tmr_next   = step_cyc;
				end else
					tmr_next = tmr_reg - 32'h1;
			end
			FCP_DONE: begin
				// results stay until the next command starts
				rs0_next[2] = head_reg;
				if (cur_reg.op == FCP_OP_SENSE)
					rs0_next[5] = 1'b1;
				irq_next = 1'b1;
				st_next  = FCP_IDLE;
			end
			default: st_next = FCP_IDLE;
		endcase
	end

	// polling runs only while idle and enabled
	always_comb begin
		ptk_next  = 1'b0;
		poll_next = poll_reg;
		if (mode_reg[`FCP_MODE_NPOL] || st_reg != FCP_IDLE)
			poll_next = 32'h0;
		else if (poll_reg >= 32'(POLL_CYC - 1)) begin
			poll_next = 32'h0;
			ptk_next  = 1'b1;
		end else
			poll_next = poll_reg + 32'h1;
	end

	// Read data path, one cycle after the strobe
	always_comb begin
		rd_next = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				`FCP_A_CMD:    rd_next = cmd_reg;
				`FCP_A_SECT:   rd_next = sect_p_reg;
				`FCP_A_EOT:    rd_next = eot_reg;
				`FCP_A_SIZE:   rd_next = size_reg;
				`FCP_A_DLEN:   rd_next = dlen_reg;
				`FCP_A_SCNT:   rd_next = scnt_reg;
				`FCP_A_MODE:   rd_next = mode_reg;
				`FCP_A_PRECOMP_BEGIN_TRACK: rd_next = precomp_begin_track_reg;
				`FCP_A_RSTEP:  rd_next = rstep_reg;
				`FCP_A_PERP:   rd_next = {4'h0, perp_reg};
				`FCP_A_DATA:   rd_next = data_reg;
				`FCP_A_RS0:    rd_next = rs0_reg;
				`FCP_A_RS1:    rd_next = 8'h00;
				`FCP_A_RS2:    rd_next = rs2_reg;
				// Busy, request and head as live drive status
				`FCP_A_RS3:    rd_next = {st_reg != FCP_IDLE, req_reg, 5'h00, head_reg};
				`FCP_A_PCYL:   rd_next = pcn_reg;
				default:       rd_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg  <= FCP_IDLE;
			cur_reg <= '0;
			{sect_reg, head_reg, left_reg, idx_reg, data_reg, req_reg, last_reg} <= '0;
			{pcn_reg, stepl_reg, dir_reg, tmr_reg, poll_reg, rs0_reg, rs2_reg} <= '0;
			{irq_reg, sreq_reg, dwr_reg, stp_reg, ptk_reg, rd_reg} <= '0;
		end else begin
			st_reg  <= st_next;
			cur_reg <= cur_next;
			{sect_reg, head_reg, left_reg, idx_reg, data_reg, req_reg, last_reg} <=
				{sect_next, head_next, left_next, idx_next, data_next, req_next, last_next};
			{pcn_reg, stepl_reg, dir_reg, tmr_reg, poll_reg, rs0_reg, rs2_reg} <=
				{pcn_next, stepl_next, dir_next, tmr_next, poll_next, rs0_next, rs2_next};
			{irq_reg, sreq_reg, dwr_reg, stp_reg, ptk_reg, rd_reg} <=
				{irq_next, sreq_next, dwr_next, stp_next, ptk_next, rd_next};
		end
	end

	// Outputs; request is a handshake level, precompensation and write enable are decoded, the rest come from flops
	// request only in DMA mode
	assign dma_request   = req_reg && !cur_reg.programmed_io_select;
	assign host_irq      = irq_reg;
	assign rdata         = rd_reg;
	assign sector_req    = sreq_reg;
	assign sector_num    = sect_reg;
	assign head_sel      = head_reg;
	assign disk_wr_valid = dwr_reg;
	assign disk_wr_data  = data_reg;
	assign step_pulse    = stp_reg;
	assign step_dir_in   = dir_reg;
	assign poll_tick     = ptk_reg;
	assign perp_bits     = perp_reg;
	// precompensation from the start track onward
	assign precomp_on    = pcn_reg >= precomp_begin_track_reg;
	// gate bit opens write enable during the sector search too
	assign write_enable  = is_wr && (st_reg == FCP_XFER ||
		(mode_reg[`FCP_MODE_WGT] && st_reg == FCP_SECT));
endmodule

// File: include/fcp_params.svh
`ifndef FCP_PARAMS_SVH
`define FCP_PARAMS_SVH
// Register word addresses
`define FCP_A_CMD    4'h0
`define FCP_A_SECT   4'h1
`define FCP_A_EOT    4'h2
`define FCP_A_SIZE   4'h3
`define FCP_A_DLEN   4'h4
`define FCP_A_SCNT   4'h5
`define FCP_A_MODE   4'h6
`define FCP_A_PRECOMP_BEGIN_TRACK 4'h7
`define FCP_A_RSTEP  4'h8
`define FCP_A_PERP   4'h9
`define FCP_A_DATA   4'ha
`define FCP_A_RS0    4'hb
`define FCP_A_RS1    4'hc
`define FCP_A_RS2    4'hd
`define FCP_A_RS3    4'he
`define FCP_A_PCYL   4'hf
// CMD fields
`define FCP_CMD_OP   2:0
`define FCP_CMD_SPAN 4
`define FCP_CMD_SKIP 5
// MODE fields
`define FCP_MODE_PIO  0
`define FCP_MODE_EC   1
`define FCP_MODE_NPOL 2
`define FCP_MODE_WGT  3
`define FCP_MODE_SRT  7:4
// PERP fields
`define FCP_PERP_BITS 3:0
`define FCP_PERP_GATE 7
// Reset values
`define FCP_RST_BYTE  8'h00
`define FCP_RST_DLEN  8'hff
`define FCP_RST_SECT  8'h01
// Sector size base and largest code
`define FCP_BASE_BYTES 15'h0080
`define FCP_MAX_CODE   3'h7
// Timing
`define FCP_CLK_MHZ      125
`define FCP_STEP_UNIT_US 500
`define FCP_POLL_US      1000
`endif

// File: include/fcp_pkg.sv
package fcp_pkg;
	typedef enum logic [2:0] {
		FCP_OP_READ   = 3'h0,
		FCP_OP_READDEL = 3'h1,
		FCP_OP_WRITE  = 3'h2,
		FCP_OP_VERIFY = 3'h3,
		FCP_OP_FORMAT = 3'h4,
		FCP_OP_RSEEK  = 3'h5,
		FCP_OP_SENSE  = 3'h6,
		FCP_OP_NONE   = 3'h7
	} fcp_op_e;

	typedef enum logic [2:0] {
		FCP_IDLE = 3'b000,
		FCP_SECT = 3'b001,
		FCP_XFER = 3'b011,
		FCP_NEXT = 3'b010,
		FCP_DONE = 3'b110,
		FCP_STEP = 3'b100
	} fcp_state_e;

	// Parameters frozen for one command
	typedef struct packed {
		fcp_op_e    op;
		logic       cylinder_span_flag;
		logic       deleted_mark_bypass;
		logic       programmed_io_select;
		logic       verify_count_enable;
		logic [2:0] size_code;
		logic [7:0] eot;
		logic [7:0] data_length_param;
		logic [7:0] sector_count;
	} fcp_cmd_s;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} fcp_bus_s;
endpackage
